//--- cag_pkg.sv
package cag_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PC = 8'h04;
  localparam logic [7:0] A_OP = 8'h08;
  localparam logic [7:0] A_WREG = 8'h0c;
  localparam logic [7:0] A_XMOD = 8'h10;
  localparam logic [7:0] A_YMOD = 8'h14;
  localparam logic [7:0] A_BREV = 8'h18;
  localparam logic [7:0] A_PAGE = 8'h1c;
  localparam logic [7:0] A_XEA = 8'h20;
  localparam logic [7:0] A_EXT = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_REP = 8'h2c;
  localparam logic [7:0] A_TBL = 8'h30;
  // ------------------------------------------------------------
  // Control bits, reset values, counts
  // ------------------------------------------------------------
  localparam int C_GO = 0;
  localparam int C_XMOD = 1;
  localparam int C_YMOD = 2;
  localparam int C_BREV = 3;
  localparam int C_PSV = 4;
  localparam int SP_IDX = 15;
  localparam logic [15:0] SP_RST = 16'h1000;
  localparam logic [22:0] PC_RST = 23'h000000;
  localparam logic [22:0] IRQ_VEC = 23'h000004;
  localparam logic [22:0] PC_INC = 23'h000002;
  localparam logic [15:0] W_INC = 16'h0002;
  localparam logic [15:0] SP_INC = 16'h0004;
  localparam logic [15:0] Y_SPLIT = 16'h0800;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_WAIT = 2'b11
  } cag_state_t;
  typedef enum logic [2:0] {
    M_INH = 3'h0, M_REL = 3'h1, M_LIT = 3'h2,
    M_DIR = 3'h3, M_RDIR = 3'h4, M_RIND = 3'h5
  } cag_mode_t;
  typedef struct packed {
    logic [15:0] lit;
    logic [3:0] ry;
    logic spare;
    logic tbl;
    logic call;
    logic wr;
    logic dual;
    logic [3:0] rs;
    logic [2:0] mode;
  } cag_op_t;
  typedef struct packed {
    logic valid;
    logic prog;
    logic wr;
    logic [23:0] addr;
  } cag_bus_t;
endpackage : cag_pkg

//--- cag_core.sv
`timescale 1ns/1ps
module cag_core #(
  parameter logic [15:0] Y_SPLIT = cag_pkg::Y_SPLIT
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt request pin
  input wire logic irq_pin,
  // Memory request side
  output cag_pkg::cag_bus_t mem_x_req,
  output logic [15:0] mem_y_addr,
  output logic addr_fault
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  cag_pkg::cag_state_t st_reg, st_next;
  cag_pkg::cag_op_t op_reg, op_next;
  logic [15:0] w_reg [16];
  logic [15:0] w_next [16];
  logic [22:0] pc_reg, pc_next;
  logic [4:0] ctrl_reg, ctrl_next;
  logic [31:0] xmod_reg, xmod_next, ymod_reg, ymod_next;
  logic [15:0] brev_reg, brev_next, rep_reg, rep_next, xea_reg, xea_next;
  logic [8:0] rpag_reg, rpag_next, wpag_reg, wpag_next;
  logic [7:0] tpag_reg, tpag_next;
  logic [3:0] wsel_reg, wsel_next;
  logic [2:0] irq_reg, irq_next;
  logic [7:0] aw_reg, aw_next;
  logic [31:0] wd_reg, wd_next, rd_next;
  logic awf_reg, awf_next, wf_reg, wf_next, bv_next, rv_next;
  logic [1:0] rr_next;
  cag_pkg::cag_bus_t mx_next;
  logic [15:0] my_next;
  logic flt_next;

  // ------------------------------------------------------------
  // Address unit helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] rev16(input logic [15:0] a);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = a[15-i];
    end
    return r;
  endfunction : rev16

  // Post-update for one unit; modulo wraps past the end to the start
  function automatic logic [15:0] upd(input logic [15:0] a,
      input logic m_en, input logic [31:0] bnd,
      input logic b_en, input logic [15:0] bm);
    logic [15:0] n;
    n = a + cag_pkg::W_INC;
    if (b_en) begin
      n = rev16(rev16(a) + rev16(bm));
    end else if (m_en && n > bnd[31:16]) begin
      n = bnd[15:0];
    end
    return n;
  endfunction : upd

  // ------------------------------------------------------------
  // Next-state logic, one engine for both classes
  // ------------------------------------------------------------
  logic [15:0] ea, ey, rdw;
  logic flow, irq_take;
  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    w_next = w_reg;
    pc_next = pc_reg;
    ctrl_next = ctrl_reg;
    xmod_next = xmod_reg;
    ymod_next = ymod_reg;
    brev_next = brev_reg;
    rep_next = rep_reg;
    xea_next = xea_reg;
    rpag_next = rpag_reg;
    wpag_next = wpag_reg;
    tpag_next = tpag_reg;
    wsel_next = wsel_reg;
    irq_next = {irq_reg[1:0], irq_pin};
    aw_next = aw_reg;
    wd_next = wd_reg;
    awf_next = awf_reg;
    wf_next = wf_reg;
    bv_next = s_axi_bvalid & ~s_axi_bready;
    rv_next = s_axi_rvalid & ~s_axi_rready;
    rd_next = s_axi_rdata;
    rr_next = s_axi_rresp;
    mx_next = mem_x_req;
    mx_next.valid = 1'b0;
    my_next = mem_y_addr;
    flt_next = addr_fault;
    ea = '0;
    ey = '0;
    flow = 1'b0;
    rdw = w_reg[wsel_reg];
    ctrl_next[cag_pkg::C_GO] = 1'b0;
    // Irq only between steps so a step never half-completes
    irq_take = irq_reg[1] & ~irq_reg[2] & (st_reg == cag_pkg::ST_IDLE);
    case (st_reg)
      cag_pkg::ST_IDLE: begin
        if (irq_take) begin
          w_next[cag_pkg::SP_IDX] = w_reg[cag_pkg::SP_IDX]
            + cag_pkg::SP_INC;
          pc_next = cag_pkg::IRQ_VEC;
        end else if (ctrl_reg[cag_pkg::C_GO]) begin
          st_next = cag_pkg::ST_EXEC;
        end
      end
      cag_pkg::ST_EXEC: begin
        flt_next = 1'b0;
        case (op_reg.mode)
          cag_pkg::M_INH: ;
          cag_pkg::M_REL: begin
            flow = 1'b1;
            if (op_reg.call) begin
              w_next[cag_pkg::SP_IDX] = w_reg[cag_pkg::SP_IDX]
                + cag_pkg::SP_INC;
            end
            pc_next = pc_reg + {{7{op_reg.lit[15]}}, op_reg.lit};
          end
          cag_pkg::M_LIT: xea_next = op_reg.lit;
          cag_pkg::M_DIR: begin
            ea = op_reg.lit;
            mx_next.valid = 1'b1;
          end
          cag_pkg::M_RDIR: xea_next = w_reg[op_reg.rs];
          cag_pkg::M_RIND: begin
            ea = w_reg[op_reg.rs];
            mx_next.valid = 1'b1;
            w_next[op_reg.rs] = upd(ea, ctrl_reg[cag_pkg::C_XMOD],
              xmod_reg, ctrl_reg[cag_pkg::C_BREV], brev_reg);
          end
          default: flt_next = 1'b1;
        endcase
        if (op_reg.dual && op_reg.mode == cag_pkg::M_RIND) begin
          ey = w_reg[op_reg.ry];
          my_next = ey;
          w_next[op_reg.ry] = upd(ey, ctrl_reg[cag_pkg::C_YMOD],
            ymod_reg, 1'b0, brev_reg);
          if (ey < Y_SPLIT) begin
            flt_next = 1'b1;
          end
        end
        if (mx_next.valid) begin
          xea_next = ea;
          mx_next.wr = op_reg.wr;
          mx_next.prog = op_reg.tbl;
          mx_next.addr = {8'h00, ea};
          if (op_reg.tbl) begin
            mx_next.addr = {tpag_reg, ea};
          end else if (ea[15] && ctrl_reg[cag_pkg::C_PSV] && !op_reg.wr) begin
            mx_next.prog = 1'b1;
            mx_next.addr = {1'b0, tpag_reg, ea[14:0]};
          end else if (ea[15]) begin
            mx_next.addr = {op_reg.wr ? wpag_reg : rpag_reg,
              ea[14:0]};
          end
        end
        if (flow) begin
          st_next = cag_pkg::ST_WAIT;
        end else begin
          st_next = cag_pkg::ST_IDLE;
          if (rep_reg != 16'h0000) begin
            rep_next = rep_reg - 16'h0001;
          end else begin
            pc_next = pc_reg + cag_pkg::PC_INC;
          end
        end
      end
      cag_pkg::ST_WAIT: st_next = cag_pkg::ST_IDLE;
      default: st_next = cag_pkg::ST_IDLE;
    endcase
    // AXI write side takes address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = s_axi_awaddr;
      awf_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_next = s_axi_wdata;
      wf_next = 1'b1;
    end
    if (awf_reg && wf_reg && !s_axi_bvalid) begin
      awf_next = 1'b0;
      wf_next = 1'b0;
      bv_next = 1'b1;
      case (aw_reg)
        cag_pkg::A_CTRL: ctrl_next = wd_reg[4:0];
        cag_pkg::A_PC: pc_next = wd_reg[22:0];
        cag_pkg::A_OP: op_next = wd_reg;
        cag_pkg::A_WREG: begin
          wsel_next = wd_reg[19:16];
          if (wd_reg[20]) begin
            w_next[wd_reg[19:16]] = wd_reg[15:0];
          end
        end
        cag_pkg::A_XMOD: xmod_next = wd_reg;
        cag_pkg::A_YMOD: ymod_next = wd_reg;
        cag_pkg::A_BREV: brev_next = wd_reg[15:0];
        cag_pkg::A_PAGE: begin
          rpag_next = wd_reg[8:0];
          wpag_next = wd_reg[24:16];
        end
        cag_pkg::A_REP: rep_next = wd_reg[15:0];
        cag_pkg::A_TBL: tpag_next = wd_reg[7:0];
        default: ;
      endcase
    end
    // AXI read side, one outstanding
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rr_next = cag_pkg::RESP_OK;
      case (s_axi_araddr)
        cag_pkg::A_CTRL: rd_next = {27'h0, ctrl_reg};
        cag_pkg::A_PC: rd_next = {9'h0, pc_reg};
        cag_pkg::A_OP: rd_next = op_reg;
        cag_pkg::A_WREG: rd_next = {12'h0, wsel_reg, rdw};
        cag_pkg::A_XMOD: rd_next = xmod_reg;
        cag_pkg::A_YMOD: rd_next = ymod_reg;
        cag_pkg::A_BREV: rd_next = {16'h0, brev_reg};
        cag_pkg::A_PAGE: rd_next = {7'h0, wpag_reg, 7'h0, rpag_reg};
        cag_pkg::A_XEA: rd_next = {mem_y_addr, xea_reg};
        cag_pkg::A_EXT: rd_next = {5'h0, mem_x_req};
        cag_pkg::A_STAT: rd_next = {29'h0, addr_fault, st_reg};
        cag_pkg::A_REP: rd_next = {16'h0, rep_reg};
        cag_pkg::A_TBL: rd_next = {24'h0, tpag_reg};
        default: begin
          rd_next = 32'h0;
          rr_next = cag_pkg::RESP_ERR;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= cag_pkg::ST_IDLE;
      op_reg <= '0;
      for (int i = 0; i < 16; i++) begin
        w_reg[i] <= (i == cag_pkg::SP_IDX) ? cag_pkg::SP_RST : 16'h0000;
      end
      pc_reg <= cag_pkg::PC_RST;
      ctrl_reg <= '0;
      xmod_reg <= '0;
      ymod_reg <= '0;
      brev_reg <= '0;
      rep_reg <= '0;
      xea_reg <= '0;
      rpag_reg <= '0;
      wpag_reg <= '0;
      tpag_reg <= '0;
      wsel_reg <= '0;
      irq_reg <= '0;
      aw_reg <= '0;
      wd_reg <= '0;
      awf_reg <= 1'b0;
      wf_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_bresp <= cag_pkg::RESP_OK;
      s_axi_rresp <= cag_pkg::RESP_OK;
      s_axi_rdata <= '0;
      mem_x_req <= '0;
      mem_y_addr <= '0;
      addr_fault <= 1'b0;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      w_reg <= w_next;
      pc_reg <= pc_next;
      ctrl_reg <= ctrl_next;
      xmod_reg <= xmod_next;
      ymod_reg <= ymod_next;
      brev_reg <= brev_next;
      rep_reg <= rep_next;
      xea_reg <= xea_next;
      rpag_reg <= rpag_next;
      wpag_reg <= wpag_next;
      tpag_reg <= tpag_next;
      wsel_reg <= wsel_next;
      irq_reg <= irq_next;
      aw_reg <= aw_next;
      wd_reg <= wd_next;
      awf_reg <= awf_next;
      wf_reg <= wf_next;
      s_axi_awready <= ~awf_next & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~wf_next & ~(s_axi_wvalid & s_axi_wready);
      s_axi_arready <= ~rv_next & ~(s_axi_arvalid & s_axi_arready);
      s_axi_bvalid <= bv_next;
      s_axi_rvalid <= rv_next;
      s_axi_bresp <= cag_pkg::RESP_OK;
      s_axi_rresp <= rr_next;
      s_axi_rdata <= rd_next;
      mem_x_req <= mx_next;
      mem_y_addr <= my_next;
      addr_fault <= flt_next;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic exec_lin;
  assign exec_lin = st_reg == cag_pkg::ST_EXEC
    && op_reg.mode != cag_pkg::M_REL;
  property p_pc_step;
    exec_lin && rep_reg == 16'h0 && !(awf_reg && wf_reg)
      |=> pc_reg == $past(pc_reg) + cag_pkg::PC_INC;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step");
  property p_rep;
    exec_lin && rep_reg != 16'h0 && !(awf_reg && wf_reg)
      |=> $stable(pc_reg) && rep_reg == $past(rep_reg) - 16'h1;
  endproperty
  a_rep: assert property (p_rep) else $error("repeat");
  property p_flow;
    st_reg == cag_pkg::ST_EXEC && op_reg.mode == cag_pkg::M_REL
      |=> st_reg == cag_pkg::ST_WAIT ##1 st_reg == cag_pkg::ST_IDLE;
  endproperty
  a_flow: assert property (p_flow) else $error("flow wait");
  property p_irq_sp;
    irq_take && !(awf_reg && wf_reg) |=> pc_reg == cag_pkg::IRQ_VEC
      && w_reg[15] == $past(w_reg[15]) + cag_pkg::SP_INC;
  endproperty
  a_irq_sp: assert property (p_irq_sp) else $error("irq push");
  property p_ysplit;
    st_reg == cag_pkg::ST_EXEC && op_reg.dual
      && op_reg.mode == cag_pkg::M_RIND && w_reg[op_reg.ry] < Y_SPLIT
      |=> addr_fault;
  endproperty
  a_ysplit: assert property (p_ysplit) else $error("y split");
  property p_lower;
    mem_x_req.valid && mem_x_req.prog && !op_reg.tbl
      |-> !mem_x_req.addr[23];
  endproperty
  a_lower: assert property (p_lower) else $error("prog half");
  property p_eds;
    mem_x_req.valid && !mem_x_req.prog && !mem_x_req.addr[15]
      && !op_reg.tbl |-> mem_x_req.addr[23:16] == 8'h00;
  endproperty
  a_eds: assert property (p_eds) else $error("base addr");
  property p_lin;
    st_reg == cag_pkg::ST_EXEC && op_reg.mode == cag_pkg::M_RIND
      && ctrl_reg[4:1] == 4'h0 && !op_reg.dual && !(awf_reg && wf_reg)
      |=> w_reg[$past(op_reg.rs)] == $past(w_reg[op_reg.rs]) + 16'h2;
  endproperty
  a_lin: assert property (p_lin) else $error("linear");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid drop");
  c_irq: cover property (irq_take);
  c_dual: cover property (st_reg == cag_pkg::ST_EXEC && op_reg.dual);
  c_psv: cover property (mem_x_req.valid && mem_x_req.prog);
endmodule : cag_core

//--- cag_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side memory request capture
// ----------------------------------------
module cag_mem_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from the core
  input wire cag_pkg::cag_bus_t mem_x_req,
  // Observation
  output cag_pkg::cag_bus_t last_x,
  output logic [15:0] x_count
);
  // Only the address side is modelled; no read data path to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_x <= '0;
      x_count <= 16'h0000;
    end else if (mem_x_req.valid) begin
      last_x <= mem_x_req;
      x_count <= x_count + 16'h0001;
    end
  end
endmodule : cag_mem_model

//--- cag_core_tb.sv
`timescale 1ns/1ps
module cag_core_tb;
  logic aclk, aresetn, irq_pin, addr_fault;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, rb;
  cag_pkg::cag_bus_t mem_x_req, last_x;
  logic [15:0] mem_y_addr, x_count, cnt0;
  logic [22:0] exp_pc;
  int err_total, check_count, m;

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  cag_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_pin, .mem_x_req,
    .mem_y_addr, .addr_fault);
  cag_mem_model mem (.aclk, .aresetn, .mem_x_req, .last_x, .x_count);

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task wrap_up;
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task tmo(input int n);
    if (n >= 60) begin
      err_total++;
      wrap_up();
    end
  endtask : tmo

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 60) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
      if (aw_ok && w_ok && s_axi_bvalid) begin
        rb = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 60) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask : axi_rd

  // Polls a register field; a run-out still ends in a failed compare
  task wait_reg(input logic [7:0] a, input logic [31:0] mk,
                input logic [31:0] e);
    for (int k = 0; k < 40; k++) begin
      axi_rd(a);
      if ((v & mk) === e) break;
    end
    chk(v & mk, e);
  endtask : wait_reg

  task step(input logic [31:0] ctrl, input logic adv);
    axi_wr(cag_pkg::A_CTRL, ctrl | 32'h1);
    repeat (3) @(posedge aclk);
    wait_reg(cag_pkg::A_STAT, 32'h3, 32'h0);
    if (adv) exp_pc = exp_pc + cag_pkg::PC_INC;
  endtask : step

  task wreg(input logic [3:0] i, input logic [15:0] d);
    axi_wr(cag_pkg::A_WREG, {11'h0, 1'b1, i, d});
  endtask : wreg

  task rdw(input logic [3:0] i);
    axi_wr(cag_pkg::A_WREG, {12'h0, i, 16'h0});
    axi_rd(cag_pkg::A_WREG);
  endtask : rdw

  task xchk(input logic p, input logic w, input logic [23:0] a);
    chk({5'h0, last_x}, {5'h0, 1'b1, p, w, a});
  endtask : xchk

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, irq_pin} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    err_total = 0;
    check_count = 0;
    exp_pc = cag_pkg::PC_RST;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(cag_pkg::A_PC);
    chk(v, {9'h0, cag_pkg::PC_RST});
    rdw(4'hf);
    chk(v, {12'h0, 4'hf, cag_pkg::SP_RST});
    axi_rd(8'hfc);
    chk(v, 32'h0);
    chk({30'h0, r}, {30'h0, cag_pkg::RESP_ERR});
    axi_wr(8'hfc, 32'h0);
    chk({30'h0, rb}, {30'h0, cag_pkg::RESP_OK});
    // Plain and indirect steps, linear update
    axi_wr(cag_pkg::A_OP, 32'h0);
    step(32'h0, 1'b1);
    wreg(4'h5, 16'h0100);
    axi_wr(cag_pkg::A_OP, 32'h2d);
    cnt0 = x_count;
    step(32'h0, 1'b1);
    chk({16'h0, x_count - cnt0}, 32'h1);
    xchk(1'b0, 1'b0, 24'h000100);
    rdw(4'h5);
    chk(v, 32'h0005_0102);
    // Modulo wrap at the end bound
    axi_wr(cag_pkg::A_XMOD, 32'h0102_0100);
    step(32'h2, 1'b1);
    xchk(1'b0, 1'b0, 24'h000102);
    rdw(4'h5);
    chk(v, 32'h0005_0100);
    // Reverse-carry sequence 0, 8, 4
    wreg(4'h5, 16'h0000);
    axi_wr(cag_pkg::A_BREV, 32'h8);
    step(32'h8, 1'b1);
    rdw(4'h5);
    chk(v, 32'h0005_0008);
    step(32'h8, 1'b1);
    rdw(4'h5);
    chk(v, 32'h0005_0004);
    // Program window, then paged reads and writes
    wreg(4'h5, 16'h8010);
    step(32'h10, 1'b1);
    xchk(1'b1, 1'b0, 24'h000010);
    axi_wr(cag_pkg::A_PAGE, 32'h0005_0003);
    wreg(4'h5, 16'h8010);
    step(32'h0, 1'b1);
    xchk(1'b0, 1'b0, 24'h018010);
    axi_wr(cag_pkg::A_OP, 32'h12d);
    wreg(4'h5, 16'h8010);
    step(32'h0, 1'b1);
    xchk(1'b0, 1'b1, 24'h028010);
    axi_rd(cag_pkg::A_PC);
    chk(v, {9'h0, exp_pc});
    // Dual operand at the split point
    wreg(4'h6, cag_pkg::Y_SPLIT);
    axi_wr(cag_pkg::A_OP, 32'h60ad);
    step(32'h0, 1'b1);
    chk({16'h0, mem_y_addr}, {16'h0, cag_pkg::Y_SPLIT});
    chk({31'h0, addr_fault}, 32'h0);
    // Repeat holds the counter and counts down
    axi_wr(cag_pkg::A_REP, 32'h2);
    axi_wr(cag_pkg::A_OP, 32'h0);
    step(32'h0, 1'b0);
    axi_rd(cag_pkg::A_PC);
    chk(v, {9'h0, exp_pc});
    axi_rd(cag_pkg::A_REP);
    chk(v, 32'h1);
    axi_wr(cag_pkg::A_REP, 32'h0);
    // Every legal mode code runs clean
    for (m = 0; m < 6; m++) begin
      axi_wr(cag_pkg::A_OP, 32'(m));
      step(32'h0, 1'b0);
      chk(v & 32'h4, 32'h0);
    end
    // Y operand below the split, then an illegal mode
    wreg(4'h6, cag_pkg::Y_SPLIT - 16'h0002);
    axi_wr(cag_pkg::A_OP, 32'h60ad);
    step(32'h0, 1'b0);
    chk({31'h0, addr_fault}, 32'h1);
    axi_wr(cag_pkg::A_OP, 32'h7);
    step(32'h0, 1'b0);
    wait_reg(cag_pkg::A_STAT, 32'h4, 32'h4);
    // Interrupt pushes onto the stack pointer and vectors
    @(posedge aclk);
    irq_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    irq_pin <= 1'b0;
    wait_reg(cag_pkg::A_PC, 32'h7fffff, {9'h0, cag_pkg::IRQ_VEC});
    rdw(4'hf);
    chk(v, {12'h0, 4'hf, cag_pkg::SP_RST + cag_pkg::SP_INC});
    // Relative call pushes and jumps by the literal offset
    axi_wr(cag_pkg::A_OP, 32'h0010_0201);
    step(32'h0, 1'b0);
    axi_rd(cag_pkg::A_PC);
    chk(v, {9'h0, cag_pkg::IRQ_VEC + 23'h000010});
    rdw(4'hf);
    chk(v, {12'h0, 4'hf, cag_pkg::SP_RST + 16'h0008});
    // Literal and register direct land in the effective value
    axi_wr(cag_pkg::A_OP, 32'h1234_0002);
    step(32'h0, 1'b0);
    axi_rd(cag_pkg::A_XEA);
    chk(v & 32'hffff, 32'h1234);
    wreg(4'h5, 16'h0abc);
    axi_wr(cag_pkg::A_OP, 32'h2c);
    step(32'h0, 1'b0);
    axi_rd(cag_pkg::A_XEA);
    chk(v & 32'hffff, 32'h0abc);
    // Table read into the upper program half
    axi_wr(cag_pkg::A_TBL, 32'h80);
    wreg(4'h5, 16'h0020);
    axi_wr(cag_pkg::A_OP, 32'h42d);
    step(32'h0, 1'b0);
    xchk(1'b1, 1'b0, 24'h800020);
    // Y modulo wrap on a dual step
    axi_wr(cag_pkg::A_YMOD, 32'h0802_0800);
    wreg(4'h6, 16'h0802);
    axi_wr(cag_pkg::A_OP, 32'h60ad);
    step(32'h4, 1'b0);
    rdw(4'h6);
    chk(v, 32'h0006_0800);
    wrap_up();
  end
endmodule : cag_core_tb
